/* rtl/dcc_top.sv */
// Digital output functions and motor contactor sequencing with APB registers
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`include "dcc_regs.svh"
module dcc_top import dcc_pkg::*; #(
   parameter int unsigned MS_CYCLES = `DCC_MS_CYCLES
) (
   // Clock and reset
   input  wire logic               i_clk,
   input  wire logic               i_rst_n,
   // APB slave
   input  wire logic               i_psel,
   input  wire logic               i_penable,
   input  wire logic               i_pwrite,
   input  wire logic [7:0]         i_paddr,
   input  wire logic [31:0]        i_pwdata,
   output logic                    o_pready,
   output logic [31:0]             o_prdata,
   output logic                    o_pslverr,
   // Control sequencer
   input  wire logic               i_start,
   input  wire logic               i_autotune,
   input  wire logic               i_stopped,
   input  wire logic               i_power_on,
   // Measured and reference values
   input  wire logic signed [15:0] i_torque,
   input  wire logic signed [15:0] i_ref_target,
   input  wire logic signed [15:0] i_ref_ramp,
   input  wire logic signed [15:0] i_actual,
   // Outputs
   output logic [2:0]              o_standard_digital_output,
   output logic                    o_expansion_digital_output,
   output logic                    o_ref_enable,
   output logic                    o_holding_brake_function
);
   dcc_mode_t   mode_reg;        // Active control mode
   logic [31:0] funcsel_reg;     // Four 8-bit output selectors
   logic [15:0] delay_reg;       // Contactor delay, ms
   logic [15:0] tq_limit_reg;    // Torque warning limit
   logic [15:0] tol_reg;         // Reference tolerance band
   logic        brake_reg;       // Holding brake function on
   logic        reject_reg;      // Last brake write refused
   dcc_state_t  state_reg;       // Contactor sequencer
   dcc_state_t  state_next;
   logic        ctc_on;          // Contactor closed
   logic        ctc_en;          // Contactor control enabled
   logic        go;              // Start or auto-tuning
   logic        timer_load;
   logic        timer_cancel;
   logic        timer_done;
   logic        tq_warn;
   logic        ref_hit;
   logic        standstill;
   logic        running;
   logic        acc;             // APB access phase
   logic        wr_ok;           // Write taking effect now
   logic        mapped;
   logic [31:0] rd_data;
   logic [3:0]  dout_next;

   // True when a is within +/- tol of b
   function automatic logic in_band(input logic signed [15:0] a,
                                    input logic signed [15:0] b,
                                    input logic [15:0]        tol);
      logic signed [16:0] d;
      logic [16:0]        mag;
      d   = 17'(a) - 17'(b);
      mag = d[16] ? 17'(-d) : 17'(d);
      return mag <= {1'b0, tol};
   endfunction

   // True when the selector names either contactor function
   function automatic logic is_ctc(input logic [7:0] sel);
      return (sel == `DCC_FN_CTC) || (sel == `DCC_FN_CTC_NEG);
   endfunction

   // Level of one output for the given selector
   function automatic logic fn_level(input logic [7:0] sel,
                                     input logic       w, r, s, c);
      case (sel)
         `DCC_FN_TQ_WARN:    return w;
         `DCC_FN_REF:        return r;
         `DCC_FN_STANDSTILL: return s;
         `DCC_FN_CTC:        return c;
         `DCC_FN_CTC_NEG:    return ~c;
         default:            return 1'b0;
      endcase
   endfunction

   // Contactor control active only with a selector and a nonzero delay
   assign ctc_en = (is_ctc(funcsel_reg[7:0]) || is_ctc(funcsel_reg[15:8]) ||
                    is_ctc(funcsel_reg[23:16]) || is_ctc(funcsel_reg[31:24])) &&
                   (delay_reg != 16'h0000);
   assign go      = i_start | i_autotune;
   assign running = i_power_on | ~i_stopped;
   assign ctc_on  = (state_reg != DCC_ST_OPEN);

   // Torque above limit raises the warning
   assign tq_warn = i_torque > $signed(tq_limit_reg);

   // Source depends on mode; slip-based modes use the ramped reference
   always_comb begin
      if (mode_reg == DCC_MODE_FIELD_ORIENTED) begin
         ref_hit    = in_band(i_actual, i_ref_target, tol_reg);
         standstill = in_band(i_actual, 16'sh0000, tol_reg);
      end else begin
         ref_hit    = in_band(i_ref_ramp, i_ref_target, tol_reg);
         standstill = in_band(i_ref_ramp, 16'sh0000, tol_reg);
      end
   end

   // Contactor sequencer next state and timer requests
   always_comb begin
      state_next   = state_reg;
      timer_load   = 1'b0;
      timer_cancel = 1'b0;
      if (!ctc_en) begin
         // Leaving control disabled opens the contactor at once
         state_next   = DCC_ST_OPEN;
         timer_cancel = 1'b1;
      end else begin
         unique case (state_reg)
            DCC_ST_OPEN: begin
               if (go) begin
                  state_next = DCC_ST_PICKUP;
                  timer_load = 1'b1;
               end
            end
            DCC_ST_PICKUP: begin
               if (!go) begin
                  state_next   = DCC_ST_WAIT_STOP;
                  timer_cancel = 1'b1;
               end else if (timer_done) begin
                  state_next = DCC_ST_RUN;
               end
            end
            DCC_ST_RUN: begin
               if (!go) begin
                  state_next = DCC_ST_WAIT_STOP;
               end
            end
            DCC_ST_WAIT_STOP: begin
               if (go) begin
                  state_next = DCC_ST_RUN;
               end else if (i_stopped && !i_power_on) begin
                  // Hold closed until the power stage is really off
                  state_next = DCC_ST_DROP;
                  timer_load = 1'b1;
               end
            end
            DCC_ST_DROP: begin
               if (go) begin
                  state_next   = DCC_ST_RUN;
                  timer_cancel = 1'b1;
               end else if (i_power_on || !i_stopped) begin
                  // Stage came back on: stay closed until it stops again
                  state_next   = DCC_ST_WAIT_STOP;
                  timer_cancel = 1'b1;
               end else if (timer_done) begin
                  state_next = DCC_ST_OPEN;
               end
            end
         endcase
      end
   end

   // Sequencer state
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= DCC_ST_OPEN;
      end else begin
         state_reg <= state_next;
      end
   end

   // Delay timer
   dcc_delay_timer #(
      .MS_CYCLES (MS_CYCLES)
   ) u_timer (
      .i_clk    (i_clk),
      .i_rst_n  (i_rst_n),
      .i_load   (timer_load),
      .i_cancel (timer_cancel),
      .i_ms     (delay_reg),
      .o_done   (timer_done)
   );

   // Output levels, one selector per output
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         dout_next[i] = fn_level(funcsel_reg[8*i +: 8], tq_warn, ref_hit,
                                 standstill, ctc_on);
      end
   end

   // Output flops
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_standard_digital_output  <= 3'h0;
         o_expansion_digital_output <= 1'b0;
         o_ref_enable               <= 1'b0;
      end else begin
         o_standard_digital_output  <= dout_next[2:0];
         o_expansion_digital_output <= dout_next[3];
         // Without contactor control the reference follows start or auto-tuning
         o_ref_enable <= ctc_en ? (state_next == DCC_ST_RUN) : go;
      end
   end

   // APB handshake: one wait state, write lands on the pready edge
   assign acc    = i_psel & i_penable;
   assign wr_ok  = acc & o_pready & i_pwrite;
   assign mapped = (i_paddr[1:0] == 2'h0) && (i_paddr <= `DCC_OFF_STATUS);

   // Read multiplexer
   always_comb begin
      rd_data = 32'h0000_0000;
      case (i_paddr)
         `DCC_OFF_MODE:      rd_data[1:0] = mode_reg;
         `DCC_OFF_FUNCSEL:   rd_data = funcsel_reg;
         `DCC_OFF_CTC_DELAY: rd_data[15:0] = delay_reg;
         `DCC_OFF_TQ_LIMIT:  rd_data[15:0] = tq_limit_reg;
         `DCC_OFF_REF_TOL:   rd_data[15:0] = tol_reg;
         `DCC_OFF_WARN:      rd_data[`DCC_WARN_TQ_BIT] = tq_warn;
         `DCC_OFF_BRAKE:     rd_data[0] = brake_reg;
         `DCC_OFF_STATUS: begin
            rd_data[`DCC_ST_CTC_BIT]   = ctc_on;
            rd_data[`DCC_ST_REFEN_BIT] = o_ref_enable;
            rd_data[`DCC_ST_REJ_BIT]   = reject_reg;
            rd_data[`DCC_ST_CTCEN_BIT] = ctc_en;
         end
         default:            rd_data = 32'h0000_0000;
      endcase
   end

   // Bus answer flops
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pready  <= 1'b0;
         o_prdata  <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end else begin
         o_pready  <= acc & ~o_pready;
         o_pslverr <= acc & ~o_pready & ~mapped;
         if (acc && !o_pready && !i_pwrite) begin
            o_prdata <= rd_data;
         end
      end
   end

   // Configuration registers
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mode_reg     <= dcc_mode_t'(`DCC_RST_MODE);
         funcsel_reg  <= `DCC_RST_FUNCSEL;
         delay_reg    <= `DCC_RST_CTC_DELAY;
         tq_limit_reg <= `DCC_RST_TQ_LIMIT;
         tol_reg      <= `DCC_RST_REF_TOL;
      end else if (wr_ok) begin
         case (i_paddr)
            `DCC_OFF_MODE: begin
               // Unused mode code is ignored
               if (i_pwdata[1:0] != 2'h3) begin
                  mode_reg <= dcc_mode_t'(i_pwdata[1:0]);
               end
            end
            `DCC_OFF_FUNCSEL:   funcsel_reg  <= i_pwdata;
            `DCC_OFF_CTC_DELAY: delay_reg    <= i_pwdata[15:0];
            `DCC_OFF_TQ_LIMIT:  tq_limit_reg <= i_pwdata[15:0];
            `DCC_OFF_REF_TOL:   tol_reg      <= i_pwdata[15:0];
            default:            ;
         endcase
      end
   end

   // Brake function: changes refused while the drive runs
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         brake_reg  <= 1'b0;
         reject_reg <= 1'b0;
      end else if (wr_ok && i_paddr == `DCC_OFF_BRAKE) begin
         if (running) begin
            reject_reg <= 1'b1;
         end else begin
            brake_reg  <= i_pwdata[0];
            reject_reg <= 1'b0;
         end
      end
   end

   // Brake level straight from its register flop
   assign o_holding_brake_function = brake_reg;

   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   ctc_start_close_a: assert property (ctc_en && go && state_reg == DCC_ST_OPEN |=> ctc_on)
      else $error("contactor did not close on start");
   ctc_neg_out_a: assert property (
      ctc_en && funcsel_reg[15:8] == `DCC_FN_CTC_NEG && $stable(funcsel_reg)
      |=> o_standard_digital_output[1] == ~$past(ctc_on))
      else $error("negated contactor output wrong");
   tq_warn_out_a: assert property (
      funcsel_reg[23:16] == `DCC_FN_TQ_WARN && $stable(funcsel_reg)
      |=> o_standard_digital_output[2] == $past(tq_warn))
      else $error("torque warning output wrong");
   brake_reject_a: assert property (wr_ok && i_paddr == `DCC_OFF_BRAKE && running
      |=> $stable(brake_reg) && reject_reg)
      else $error("brake change accepted while running");
   zero_delay_off_a: assert property (delay_reg == 16'h0000 |=> !ctc_on)
      else $error("contactor closed with zero delay");
   tune_closed_a: assert property (ctc_en && i_autotune && ctc_on |=> ctc_on)
      else $error("contactor opened during auto-tuning");
   ref_after_delay_a: assert property (ctc_en && o_ref_enable |-> ctc_on)
      else $error("reference applied with contactor open");
   hold_power_a: assert property (ctc_on && (i_power_on || !i_stopped) && ctc_en
      |=> ctc_on)
      else $error("contactor released with power stage on");
   drop_cancel_a: assert property (state_reg == DCC_ST_DROP && go && ctc_en
      |=> state_reg == DCC_ST_RUN)
      else $error("delay not cancelled on restart");

   run_seq_c: cover property (state_reg == DCC_ST_PICKUP ##[1:1000] state_reg == DCC_ST_RUN);
   drop_seq_c: cover property (state_reg == DCC_ST_DROP ##1 state_reg == DCC_ST_OPEN);
   // Restart while the drop delay is still running
   restart_c: cover property (state_reg == DCC_ST_DROP && go && ctc_en);
   reject_c: cover property (wr_ok && i_paddr == `DCC_OFF_BRAKE && running);
endmodule

/* rtl/dcc_regs.svh */
// Register offsets, field positions, reset values, function codes and timing counts
`ifndef DCC_REGS_SVH
`define DCC_REGS_SVH
// Byte offsets of the register words
`define DCC_OFF_MODE      8'h00
`define DCC_OFF_FUNCSEL   8'h04
`define DCC_OFF_CTC_DELAY 8'h08
`define DCC_OFF_TQ_LIMIT  8'h0C
`define DCC_OFF_REF_TOL   8'h10
`define DCC_OFF_WARN      8'h14
`define DCC_OFF_BRAKE     8'h18
`define DCC_OFF_STATUS    8'h1C
// Reset values
`define DCC_RST_MODE      2'h0
`define DCC_RST_FUNCSEL   32'h0000_0000
`define DCC_RST_CTC_DELAY 16'h0000
`define DCC_RST_TQ_LIMIT  16'h7FFF
`define DCC_RST_REF_TOL   16'h0000
// Output function selector codes
`define DCC_FN_OFF        8'h00
`define DCC_FN_REF        8'h0A
`define DCC_FN_STANDSTILL 8'h0B
`define DCC_FN_TQ_WARN    8'h23
`define DCC_FN_CTC        8'h24
`define DCC_FN_CTC_NEG    8'h25
// Field positions
`define DCC_WARN_TQ_BIT   0
`define DCC_ST_CTC_BIT    0
`define DCC_ST_REFEN_BIT  1
`define DCC_ST_REJ_BIT    2
`define DCC_ST_CTCEN_BIT  3
// Timing: delay unit is one millisecond
`define DCC_CLK_NS        50
`define DCC_MS_NS         1000000
`define DCC_MS_CYCLES     (`DCC_MS_NS / `DCC_CLK_NS)
`endif

/* rtl/dcc_pkg.sv */
// Types shared by the digital output and contactor control block
package dcc_pkg;
   // Active control mode
   typedef enum logic [1:0] {
      DCC_MODE_VOLT_FREQ,
      DCC_MODE_SENSORLESS_FLUX,
      DCC_MODE_FIELD_ORIENTED
   } dcc_mode_t;
   // Contactor sequencer states
   typedef enum logic [2:0] {
      DCC_ST_OPEN,
      DCC_ST_PICKUP,
      DCC_ST_RUN,
      DCC_ST_WAIT_STOP,
      DCC_ST_DROP
   } dcc_state_t;
endpackage

/* rtl/dcc_delay_timer.sv */
// Millisecond down-counter for the contactor delay
`timescale 1ns/100ps
module dcc_delay_timer #(
   parameter int unsigned MS_CYCLES = 20000
) (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   // Control
   input  wire logic        i_load,     // Restart with full count
   input  wire logic        i_cancel,   // Abandon the running count
   input  wire logic [15:0] i_ms,       // Delay in milliseconds
   // Status
   output logic             o_done      // One-cycle pulse at expiry
);
   logic [31:0] pre_reg;   // Cycles within the current millisecond
   logic [15:0] ms_reg;    // Whole milliseconds left
   logic        run_reg;   // Count in progress

   // Load wins over cancel so a restart is never lost
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         run_reg <= 1'b0;
         pre_reg <= 32'h0000_0000;
         ms_reg  <= 16'h0000;
         o_done  <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (i_load) begin
            run_reg <= (i_ms != 16'h0000);
            pre_reg <= 32'h0000_0000;
            ms_reg  <= i_ms;
            o_done  <= (i_ms == 16'h0000);
         end else if (i_cancel) begin
            run_reg <= 1'b0;
         end else if (run_reg) begin
            if (pre_reg == MS_CYCLES - 1) begin
               pre_reg <= 32'h0000_0000;
               ms_reg  <= ms_reg - 16'h0001;
               // Last millisecond ends the count
               if (ms_reg == 16'h0001) begin
                  run_reg <= 1'b0;
                  o_done  <= 1'b1;
               end
            end else begin
               pre_reg <= pre_reg + 32'h0000_0001;
            end
         end
      end
   end
endmodule

/* tb/dcc_contactor_model.sv */
// Model of the motor contactor and the machine's power stage beside the block
`timescale 1ns/100ps
module dcc_contactor_model #(
   parameter int unsigned PICKUP = 2,  // Cycles until contacts settle closed
   parameter int unsigned STOP   = 3   // Cycles from power off to standstill
) (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   // From the block and the sequencer
   input  wire logic i_coil,           // Contactor coil drive
   input  wire logic i_run,            // Start command
   input  wire logic i_ref_en,         // Reference released to the stage
   // To the block and the bench
   output logic      o_power_on,       // Power stage enabled
   output logic      o_stopped,        // Motor at rest
   output logic      o_fault           // Contacts switched under power
);
   int unsigned closed_cnt;            // Cycles since coil closed
   int unsigned stop_cnt;              // Cycles since power off
   assign o_stopped = (stop_cnt == STOP) && !o_power_on;
   // Bounce time must fit inside the configured delay, else a fault latches
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         closed_cnt <= 0;
         stop_cnt   <= STOP;
         o_power_on <= 1'b0;
         o_fault    <= 1'b0;
      end else begin
         closed_cnt <= !i_coil ? 0 : (closed_cnt == PICKUP) ? PICKUP : closed_cnt + 1;
         o_power_on <= i_run & i_ref_en;
         stop_cnt   <= o_power_on ? 0 : (stop_cnt == STOP) ? STOP : stop_cnt + 1;
         // Stage may run only on settled contacts
         if (o_power_on && closed_cnt != PICKUP) begin
            o_fault <= 1'b1;
         end
      end
   end
endmodule

/* tb/testbench.sv */
// Self-checking bench for the digital output and contactor control block
`timescale 1ns/100ps
`include "dcc_regs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
   $display("ERROR at %0t: got %0h expected %0h", $time, g, e); end end
`define WAITC(c, l) begin n = 0; while (!(c) && n < l) begin @(negedge i_clk); n++; end \
   if (!(c)) err_count++; end
module testbench;
   // Stimulus and observed signals
   logic               i_clk, i_rst_n, psel, penable, pwrite, start, autotune, sel_exp;
   logic [7:0]         paddr;
   logic [31:0]        pwdata, prdata, q;
   logic               pready, pslverr, perr, ref_en, brake, exp_out;
   logic               power_on, stopped, fault;
   logic [2:0]         std_out;
   logic signed [15:0] torque, ref_target, ref_ramp, actual;
   int                 err_count, tests_run, n;
   // Short millisecond keeps runs brief; delay of 2 ms is 8 cycles
   dcc_top #(.MS_CYCLES(4)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .i_start(start),
      .i_autotune(autotune), .i_stopped(stopped), .i_power_on(power_on),
      .i_torque(torque), .i_ref_target(ref_target), .i_ref_ramp(ref_ramp),
      .i_actual(actual), .o_standard_digital_output(std_out),
      .o_expansion_digital_output(exp_out), .o_ref_enable(ref_en),
      .o_holding_brake_function(brake));
   // Contactor watches whichever output carries the switch function
   dcc_contactor_model #(.PICKUP(2), .STOP(3)) partner (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_coil(sel_exp ? exp_out : std_out[0]), .i_run(start), .i_ref_en(ref_en),
      .o_power_on(power_on), .o_stopped(stopped), .o_fault(fault));
   // Clock
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   // One APB transfer; pready sampled at the rising edge that ends the access
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      begin
         @(posedge i_clk);
         psel    <= 1'b1;
         penable <= 1'b0;
         pwrite  <= wr;
         paddr   <= a;
         pwdata  <= d;
         @(posedge i_clk);
         penable <= 1'b1;
         k = 0;
         do begin
            @(posedge i_clk);
            k++;
         end while (pready !== 1'b1 && k < 20);
         if (pready !== 1'b1) err_count++;
         q = prdata;
         perr = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   // Masked read compare
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(q & m, e)
   endtask
   // Let registered outputs follow new inputs
   task automatic settle();
      repeat (3) @(posedge i_clk);
   endtask
   // Verdict and end of run
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge i_clk);
      err_count++;
      print_verdict();
   end
   // Main sequence
   initial begin
      {psel, penable, pwrite, start, autotune, sel_exp} = 6'h00;
      {paddr, pwdata, torque, ref_target, ref_ramp, actual} = '0;
      err_count = 0;
      tests_run = 0;
      i_rst_n = 1'b0;
      repeat (3) @(posedge i_clk);
      i_rst_n <= 1'b1;
      // Reset values and refused addresses
      rd(`DCC_OFF_MODE, 32'hFFFF_FFFF, 32'h0000_0000);
      rd(`DCC_OFF_FUNCSEL, 32'hFFFF_FFFF, 32'h0000_0000);
      rd(`DCC_OFF_TQ_LIMIT, 32'h0000_FFFF, 32'h0000_7FFF);
      rd(`DCC_OFF_REF_TOL, 32'hFFFF_FFFF, 32'h0000_0000);
      apb(1'b0, 8'h20, 32'h0000_0000);
      `CHK(perr, 1'b1)
      apb(1'b1, 8'h02, 32'h0000_0001);
      `CHK(perr, 1'b1)
      rd(`DCC_OFF_MODE, 32'hFFFF_FFFF, 32'h0000_0000);
      // Torque warning, signed compare against the limit
      apb(1'b1, `DCC_OFF_FUNCSEL, 32'h0A23_2524);
      apb(1'b1, `DCC_OFF_TQ_LIMIT, 32'h0000_0064);
      torque <= 16'sd101;
      settle();
      `CHK(std_out[2], 1'b1)
      rd(`DCC_OFF_WARN, 32'h0000_0001, 32'h0000_0001);
      torque <= 16'sd100;
      settle();
      `CHK(std_out[2], 1'b0)
      apb(1'b1, `DCC_OFF_TQ_LIMIT, 32'h0000_FFF6);
      torque <= -16'sd5;
      settle();
      `CHK(std_out[2], 1'b1)
      // Reference reached: ramp in V/f and flux modes, actual in oriented mode
      apb(1'b1, `DCC_OFF_REF_TOL, 32'h0000_0005);
      {ref_ramp, ref_target, actual} <= {16'sd100, 16'sd104, 16'sd0};
      settle();
      `CHK(exp_out, 1'b1)
      apb(1'b1, `DCC_OFF_MODE, 32'h0000_0002);
      settle();
      `CHK(exp_out, 1'b0)
      actual <= 16'sd99;
      settle();
      `CHK(exp_out, 1'b1)
      ref_target <= 16'sd106;
      settle();
      `CHK(exp_out, 1'b0)
      apb(1'b1, `DCC_OFF_MODE, 32'h0000_0003);
      rd(`DCC_OFF_MODE, 32'h0000_0003, 32'h0000_0002);
      apb(1'b1, `DCC_OFF_FUNCSEL, 32'h0B23_2524);
      actual <= 16'sd3;
      settle();
      `CHK(exp_out, 1'b1)
      apb(1'b1, `DCC_OFF_MODE, 32'h0000_0001);
      settle();
      `CHK(exp_out, 1'b0)
      apb(1'b1, `DCC_OFF_FUNCSEL, 32'h0A23_2524);
      // Contactor run: close, delayed reference, hold through stop
      apb(1'b1, `DCC_OFF_CTC_DELAY, 32'h0000_0002);
      @(posedge i_clk) start <= 1'b1;
      `WAITC(std_out[0] === 1'b1, 5)
      `CHK(std_out[1:0], 2'b01)
      `WAITC(ref_en === 1'b1, 20)
      `CHK(n >= 6 && n < 20, 1'b1)
      rd(`DCC_OFF_STATUS, 32'h0000_000F, 32'h0000_000B);
      apb(1'b1, `DCC_OFF_BRAKE, 32'h0000_0001);
      rd(`DCC_OFF_BRAKE, 32'h0000_0001, 32'h0000_0000);
      rd(`DCC_OFF_STATUS, 32'h0000_0004, 32'h0000_0004);
      @(posedge i_clk) start <= 1'b0;
      `WAITC(std_out[0] === 1'b0, 40)
      `CHK(n >= 12 && n < 20, 1'b1)
      `CHK(std_out[1], 1'b1)
      apb(1'b1, `DCC_OFF_BRAKE, 32'h0000_0001);
      @(negedge i_clk);
      `CHK(brake, 1'b1)
      rd(`DCC_OFF_STATUS, 32'h0000_0004, 32'h0000_0000);
      // Restart during the drop delay, then a full delay again
      @(posedge i_clk) start <= 1'b1;
      `WAITC(ref_en === 1'b1, 30)
      @(posedge i_clk) start <= 1'b0;
      repeat (8) @(negedge i_clk);
      `CHK(std_out[0], 1'b1)
      @(posedge i_clk) start <= 1'b1;
      `WAITC(ref_en === 1'b1, 4)
      `CHK(ref_en, 1'b1)
      @(posedge i_clk) start <= 1'b0;
      `WAITC(std_out[0] === 1'b0, 40)
      `CHK(n >= 12 && n < 20, 1'b1)
      // Auto-tuning closes the contactor
      @(posedge i_clk) autotune <= 1'b1;
      `WAITC(std_out[0] === 1'b1, 5)
      `CHK(std_out[0], 1'b1)
      @(posedge i_clk) autotune <= 1'b0;
      `WAITC(std_out[0] === 1'b0, 30)
      // Switch function on the expansion output only
      apb(1'b1, `DCC_OFF_FUNCSEL, 32'h2400_0000);
      sel_exp <= 1'b1;
      @(posedge i_clk) start <= 1'b1;
      `WAITC(exp_out === 1'b1, 5)
      `CHK({exp_out, std_out}, 4'h8)
      `WAITC(ref_en === 1'b1, 20)
      @(posedge i_clk) start <= 1'b0;
      `WAITC(exp_out === 1'b0, 40)
      `CHK(fault, 1'b0)
      // Zero delay: contactor control off, reference follows start
      apb(1'b1, `DCC_OFF_CTC_DELAY, 32'h0000_0000);
      apb(1'b1, `DCC_OFF_FUNCSEL, 32'h0000_0024);
      sel_exp <= 1'b0;
      @(posedge i_clk) start <= 1'b1;
      settle();
      `CHK({ref_en, std_out[0]}, 2'b10)
      rd(`DCC_OFF_STATUS, 32'h0000_0008, 32'h0000_0000);
      print_verdict();
   end
endmodule
